// ---- core/rscr_defines.svh ----
`ifndef RSCR_DEFINES_SVH
`define RSCR_DEFINES_SVH

// command codes and status
`define RSCR_CMD_SET      8'h60
`define RSCR_CMD_GET      8'h61
`define RSCR_STATUS_OK    8'h00
// report layout
`define RSCR_LAST_IDX     6'h3F
`define RSCR_IDX_CODE     6'h00
`define RSCR_IDX_STATUS   6'h01
`define RSCR_IDX_CHIP_LEN 6'h02
`define RSCR_IDX_PIN_LEN  6'h03
`define RSCR_IDX_CHIP     6'h04
`define RSCR_IDX_CLKOUT   6'h05
`define RSCR_IDX_DAC      6'h06
// settings area lengths
`define RSCR_CHIP_LEN     8'h03
`define RSCR_PIN_LEN      8'h04
// security mode codes
`define RSCR_SEC_UNSECURED 2'h0
`define RSCR_SEC_PASSWORD  2'h1
`define RSCR_SEC_LOCKED    2'h2
// clock output duty codes
`define RSCR_DUTY_50      2'h0
`define RSCR_DUTY_25      2'h1
`define RSCR_DUTY_75      2'h2
// reset values
`define RSCR_BYTE_RESET   8'h00
`define RSCR_IDX_RESET    6'h00

`endif

// ---- core/rscr_pkg.sv ----
package rscr_pkg;
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b01,
    ST_SEND    = 2'b10
  } rscr_state_e;
endpackage

// ---- core/rscr_clk_out.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rscr_defines.svh"

// divided clock with selectable duty
module rscr_clk_out (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // setting
  input  wire logic       en,
  input  wire logic [1:0] duty,
  input  wire logic [2:0] div,
  // pin
  output logic            clk_pin
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_clk_pin;
  logic [8:0] period;
  logic [8:0] high_len;

  always_comb begin
    period = 9'h002 << div;
    case (duty)
      `RSCR_DUTY_25: high_len = period >> 2;
      `RSCR_DUTY_75: high_len = period - (period >> 2);
      default:       high_len = period >> 1;
    endcase
    next_cnt = cnt + 8'h01;
    if ({1'b0, cnt} >= period - 9'h001 || !en) begin
      next_cnt = 8'h00;
    end
    next_clk_pin = en && ({1'b0, next_cnt} < high_len);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt     <= 8'h00;
      clk_pin <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      clk_pin <= next_clk_pin;
    end
  end

  a_clk_idle_low: assert property (@(posedge clk) disable iff (!resetn)
    !en |=> !clk_pin)
    else $error("clock output active while disabled");

endmodule
`default_nettype wire

// ---- core/rscr_responder.sv ----
// Functional notes
// - set command answered with 0x60, 0x00
// - get command answered with 0x61, 0x00
// - bytes 2,3 carry area lengths
// - byte4 bit7 reports serial enumeration enable
// - rx indicator inverts idle level while receiving
// - tx indicator inverts idle level while sending
// - i2c indicator inverts idle level when active
// - suspend indicator inverts idle level in suspend
// - configured indicator inverts idle level once configured
// - byte4 bits1-0 report security mode
// - byte5 clock setting drives divided clock output
// - clock bits4-3 duty, bits2-0 divider
// - byte6 bits7-6 internal reference level
// - byte6 bit5 selects internal or supply reference
`timescale 1ns/1ns
`default_nettype none
`include "rscr_defines.svh"

module rscr_responder (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // command report stream
  input  wire logic       CMD_VALID,
  input  wire logic [7:0] CMD_DATA,
  output logic            CMD_READY,
  // response report stream
  output logic            RSP_VALID,
  output logic [7:0]      RSP_DATA,
  output logic            RSP_LAST,
  input  wire logic       RSP_READY,
  // run-time chip settings
  input  wire logic       SET_SERIAL_ENUM,
  input  wire logic       SET_RX_IDLE,
  input  wire logic       SET_TX_IDLE,
  input  wire logic       SET_I2C_IDLE,
  input  wire logic       SET_SUSPEND_IDLE,
  input  wire logic       SET_CONFIGURED_IDLE,
  input  wire logic [1:0] SET_SECURITY,
  input  wire logic [4:0] SET_CLKOUT,
  input  wire logic [1:0] SET_INTERNAL_REFERENCE_LEVEL,
  input  wire logic       SET_DAC_REF_INTERNAL,
  // pin designations
  input  wire logic       RX_IND_EN,
  input  wire logic       TX_IND_EN,
  input  wire logic       I2C_IND_EN,
  input  wire logic       SUSPEND_IND_EN,
  input  wire logic       CONFIGURED_IND_EN,
  input  wire logic       CLKOUT_EN,
  // device activity
  input  wire logic       UART_RX_BUSY,
  input  wire logic       UART_TX_BUSY,
  input  wire logic       I2C_BUSY,
  input  wire logic       USB_SUSPENDED,
  input  wire logic       USB_CONFIGURED,
  // indicator and clock pins
  output logic            RX_ACTIVITY_INDICATOR,
  output logic            TX_ACTIVITY_INDICATOR,
  output logic            I2C_ACTIVITY_INDICATOR,
  output logic            SUSPEND_INDICATOR,
  output logic            CONFIGURED_INDICATOR,
  output logic            CLKOUT_PIN
);

  rscr_pkg::rscr_state_e state;
  rscr_pkg::rscr_state_e next_state;
  logic [5:0] cmd_idx;
  logic [5:0] next_cmd_idx;
  logic [7:0] cmd_code;
  logic [7:0] next_cmd_code;
  logic [5:0] rsp_idx;
  logic [5:0] next_rsp_idx;
  logic [7:0] next_rsp_data;
  logic [7:0] code_now;
  logic [4:0] next_ind;
  logic [4:0] ind;

  // response byte for a given index
  function automatic logic [7:0] resp_byte(input logic [7:0] code,
                                           input logic [5:0] i);
    logic [7:0] b;
    b = `RSCR_BYTE_RESET;
    if (i == `RSCR_IDX_CODE) begin
      b = code;
    end else if (i == `RSCR_IDX_STATUS) begin
      b = `RSCR_STATUS_OK;
    end else if (code == `RSCR_CMD_GET) begin
      case (i)
        `RSCR_IDX_CHIP_LEN: b = `RSCR_CHIP_LEN;
        `RSCR_IDX_PIN_LEN:  b = `RSCR_PIN_LEN;
        `RSCR_IDX_CHIP: b = {SET_SERIAL_ENUM, SET_RX_IDLE, SET_TX_IDLE,
                             SET_I2C_IDLE, SET_SUSPEND_IDLE,
                             SET_CONFIGURED_IDLE, SET_SECURITY};
        `RSCR_IDX_CLKOUT: b = {3'h0, SET_CLKOUT};
        `RSCR_IDX_DAC: b = {SET_INTERNAL_REFERENCE_LEVEL,
                            SET_DAC_REF_INTERNAL, 5'h00};
        default: b = `RSCR_BYTE_RESET;
      endcase
    end
    return b;
  endfunction

  // command collection and response sequencing
  always_comb begin
    next_state    = state;
    next_cmd_idx  = cmd_idx;
    next_cmd_code = cmd_code;
    next_rsp_idx  = rsp_idx;
    next_rsp_data = RSP_DATA;
    code_now      = (cmd_idx == `RSCR_IDX_CODE) ? CMD_DATA : cmd_code;
    case (state)
      rscr_pkg::ST_COLLECT: begin
        if (CMD_VALID) begin
          next_cmd_idx  = cmd_idx + 6'h01;
          next_cmd_code = code_now;
          if (cmd_idx == `RSCR_LAST_IDX &&
              (code_now == `RSCR_CMD_SET ||
               code_now == `RSCR_CMD_GET)) begin
            next_state    = rscr_pkg::ST_SEND;
            next_rsp_idx  = `RSCR_IDX_RESET;
            next_rsp_data = resp_byte(code_now, `RSCR_IDX_CODE);
          end
        end
      end
      rscr_pkg::ST_SEND: begin
        if (RSP_READY) begin
          if (rsp_idx == `RSCR_LAST_IDX) begin
            next_state    = rscr_pkg::ST_COLLECT;
            next_rsp_data = `RSCR_BYTE_RESET;
          end else begin
            next_rsp_idx  = rsp_idx + 6'h01;
            next_rsp_data = resp_byte(cmd_code, rsp_idx + 6'h01);
          end
        end
      end
      default: next_state = rscr_pkg::ST_COLLECT;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state    <= rscr_pkg::ST_COLLECT;
      cmd_idx  <= `RSCR_IDX_RESET;
      cmd_code <= `RSCR_BYTE_RESET;
      rsp_idx  <= `RSCR_IDX_RESET;
      RSP_DATA <= `RSCR_BYTE_RESET;
    end else begin
      state    <= next_state;
      cmd_idx  <= next_cmd_idx;
      cmd_code <= next_cmd_code;
      rsp_idx  <= next_rsp_idx;
      RSP_DATA <= next_rsp_data;
    end
  end

  assign CMD_READY = (state == rscr_pkg::ST_COLLECT);
  assign RSP_VALID = (state == rscr_pkg::ST_SEND);
  assign RSP_LAST  = RSP_VALID && (rsp_idx == `RSCR_LAST_IDX);

  // indicator pins
  always_comb begin
    next_ind[0] = RX_IND_EN && (SET_RX_IDLE ^ UART_RX_BUSY);
    next_ind[1] = TX_IND_EN && (SET_TX_IDLE ^ UART_TX_BUSY);
    next_ind[2] = I2C_IND_EN && (SET_I2C_IDLE ^ I2C_BUSY);
    next_ind[3] = SUSPEND_IND_EN &&
                  (SET_SUSPEND_IDLE ^ USB_SUSPENDED);
    next_ind[4] = CONFIGURED_IND_EN &&
                  (SET_CONFIGURED_IDLE ^ USB_CONFIGURED);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ind <= 5'h00;
    end else begin
      ind <= next_ind;
    end
  end

  assign RX_ACTIVITY_INDICATOR  = ind[0];
  assign TX_ACTIVITY_INDICATOR  = ind[1];
  assign I2C_ACTIVITY_INDICATOR = ind[2];
  assign SUSPEND_INDICATOR      = ind[3];
  assign CONFIGURED_INDICATOR   = ind[4];

  // clock output generator
  rscr_clk_out u_clk_out (
    .clk     (CLK),
    .resetn  (RESETN),
    .en      (CLKOUT_EN),
    .duty    (SET_CLKOUT[4:3]),
    .div     (SET_CLKOUT[2:0]),
    .clk_pin (CLKOUT_PIN)
  );

  a_rsp_echo_code: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && rsp_idx == 6'h00 |->
      (RSP_DATA == 8'h60 || RSP_DATA == 8'h61))
    else $error("response byte 0 is not a command echo");

  a_rsp_status_ok: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && rsp_idx == 6'h01 |-> RSP_DATA == 8'h00)
    else $error("response status byte not zero");

  a_rsp_lengths: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && cmd_code == 8'h61 && rsp_idx == 6'h02 |->
      RSP_DATA == 8'h03)
    else $error("chip length byte wrong");

  a_pin_length: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && cmd_code == 8'h61 && rsp_idx == 6'h03 |->
      RSP_DATA == 8'h04)
    else $error("pin length byte wrong");

  a_chip_byte: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && cmd_code == 8'h61 && rsp_idx == 6'h04 |->
      RSP_DATA[1:0] != 2'h3 &&
      RSP_DATA == {SET_SERIAL_ENUM, SET_RX_IDLE, SET_TX_IDLE, SET_I2C_IDLE,
                   SET_SUSPEND_IDLE, SET_CONFIGURED_IDLE,
                   SET_SECURITY})
    else $error("chip settings byte wrong");

  a_clkout_byte: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && cmd_code == 8'h61 && rsp_idx == 6'h05 |->
      RSP_DATA == {3'h0, SET_CLKOUT})
    else $error("clock setting byte wrong");

  a_zero_fill: assert property (@(posedge CLK) disable iff (!RESETN)
    RSP_VALID && rsp_idx > 6'h06 |-> RSP_DATA == 8'h00)
    else $error("undefined response byte not zero");

  a_one_response: assert property (@(posedge CLK) disable iff (!RESETN)
    CMD_VALID && CMD_READY && cmd_idx == 6'h3F &&
      (cmd_code == 8'h61 || cmd_code == 8'h60) |=>
      RSP_VALID && rsp_idx == 6'h00 && !CMD_READY)
    else $error("accepted command did not start a response");

  a_rx_indicator: assert property (@(posedge CLK) disable iff (!RESETN)
    RX_IND_EN && UART_RX_BUSY |=>
      RX_ACTIVITY_INDICATOR == !$past(SET_RX_IDLE))
    else $error("rx indicator not inverted while receiving");

  a_tx_indicator: assert property (@(posedge CLK) disable iff (!RESETN)
    TX_IND_EN && UART_TX_BUSY |=>
      TX_ACTIVITY_INDICATOR == !$past(SET_TX_IDLE))
    else $error("tx indicator not inverted while sending");

  a_cfg_indicator: assert property (@(posedge CLK) disable iff (!RESETN)
    CONFIGURED_IND_EN && !USB_CONFIGURED |=>
      CONFIGURED_INDICATOR == $past(SET_CONFIGURED_IDLE))
    else $error("configured indicator wrong before configuration");

endmodule
`default_nettype wire

// ---- verification/rscr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module rscr_host_model (
  // clock
  input  wire logic       CLK,
  // command stream
  output logic            cmd_valid,
  output logic [7:0]      cmd_data,
  input  wire logic       cmd_ready,
  // response stream
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_last,
  output logic            rsp_ready
);
  logic [7:0] rsp_buf [64];
  int         last_at;
  initial begin
    cmd_valid = 1'b0;
    cmd_data  = 8'h00;
    rsp_ready = 1'b0;
  end
  // one 64-byte report, code first, rest zero
  task automatic send(input logic [7:0] code);
    int n;
    for (int i = 0; i < 64; i++) begin
      @(negedge CLK);
      cmd_valid = 1'b1;
      cmd_data  = (i == 0) ? code : 8'h00;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 300) begin
        @(negedge CLK);
        n++;
      end
      @(posedge CLK);
    end
    @(negedge CLK);
    cmd_valid = 1'b0;
    cmd_data  = ~cmd_data;
  endtask
  // collect one response, stalling every third cycle when slow
  task automatic recv(input bit slow);
    int k;
    int n;
    k = 0;
    n = 0;
    last_at = -1;
    while (k < 64 && n < 400) begin
      @(negedge CLK);
      rsp_ready = !(slow && n % 3 == 1);
      if (rsp_valid === 1'b1 && rsp_ready) begin
        rsp_buf[k] = rsp_data;
        if (rsp_last === 1'b1) last_at = k;
        k++;
      end
      n++;
      @(posedge CLK);
    end
    @(negedge CLK);
    rsp_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/rscr_responder_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rscr_defines.svh"
module rscr_responder_tb;
  logic       clk, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_last;
  logic       rsp_ready, ser, dac_int, ck_en, ck_pin;
  logic [7:0] cmd_data, rsp_data, cnt, xp;
  logic [1:0] sec, ref_lvl;
  logic [4:0] ck_set, ind_en, idle, busy, ind;
  logic [5:0] ck_tab [5] = '{6'h21, 6'h2A, 6'h32, 6'h38, 6'h01};
  int         n_mismatch, cmp_count, per, hi;
  rscr_host_model u_host (.CLK(clk), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
  rscr_responder u_dut (.CLK(clk), .RESETN(resetn),
    .CMD_VALID(cmd_valid), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_LAST(rsp_last),
    .RSP_READY(rsp_ready), .SET_SERIAL_ENUM(ser), .SET_RX_IDLE(idle[4]),
    .SET_TX_IDLE(idle[3]), .SET_I2C_IDLE(idle[2]),
    .SET_SUSPEND_IDLE(idle[1]), .SET_CONFIGURED_IDLE(idle[0]),
    .SET_SECURITY(sec), .SET_CLKOUT(ck_set),
    .SET_INTERNAL_REFERENCE_LEVEL(ref_lvl), .SET_DAC_REF_INTERNAL(dac_int),
    .RX_IND_EN(ind_en[4]), .TX_IND_EN(ind_en[3]), .I2C_IND_EN(ind_en[2]),
    .SUSPEND_IND_EN(ind_en[1]), .CONFIGURED_IND_EN(ind_en[0]),
    .CLKOUT_EN(ck_en), .UART_RX_BUSY(busy[4]), .UART_TX_BUSY(busy[3]),
    .I2C_BUSY(busy[2]), .USB_SUSPENDED(busy[1]), .USB_CONFIGURED(busy[0]),
    .RX_ACTIVITY_INDICATOR(ind[4]), .TX_ACTIVITY_INDICATOR(ind[3]),
    .I2C_ACTIVITY_INDICATOR(ind[2]), .SUSPEND_INDICATOR(ind[1]),
    .CONFIGURED_INDICATOR(ind[0]), .CLKOUT_PIN(ck_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one command report and its response, checked byte by byte
  task automatic exchange(input logic [7:0] code, input bit slow);
    logic [7:0] e;
    u_host.send(code);
    u_host.recv(slow);
    check("last index", u_host.last_at[7:0], 8'h3F);
    for (int i = 0; i < 64; i++) begin
      e = (i == 0) ? code : 8'h00;
      if (code == `RSCR_CMD_GET) case (i)
        2: e = `RSCR_CHIP_LEN;
        3: e = `RSCR_PIN_LEN;
        4: e = {ser, idle, sec};
        5: e = {3'h0, ck_set};
        6: e = {ref_lvl, dac_int, 5'h00};
        default: ;
      endcase
      check("rsp", u_host.rsp_buf[i], e);
    end
  endtask
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    resetn = 1'b0;
    {ser, dac_int, ck_en, sec, ref_lvl} = 7'h00;
    {ck_set, ind_en, idle, busy} = 20'h00000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check("ready", {7'h00, cmd_ready}, 8'h01);
    check("valid", {7'h00, rsp_valid}, 8'h00);
    exchange(`RSCR_CMD_SET, 1'b0);
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      sec = 2'(m % 3);
      ref_lvl = 2'(m);
      ser = m[0];
      dac_int = m[1];
      idle = m[0] ? 5'h15 : 5'h0A;
      ck_set = 5'h09 + 5'(m * 7);
      exchange(`RSCR_CMD_GET, m[0]);
    end
    u_host.send(8'h55);
    repeat (4) begin
      @(negedge clk);
      check("no answer", {7'h00, rsp_valid}, 8'h00);
    end
    exchange(`RSCR_CMD_SET, 1'b1);
    for (int c = 0; c < 8; c++) begin
      @(negedge clk);
      ind_en = c[2] ? 5'h1F : 5'h0A;
      idle = c[1] ? 5'h13 : 5'h0C;
      busy = c[0] ? 5'h19 : 5'h06;
      repeat (2) @(negedge clk);
      xp = {3'h0, ind_en & (idle ^ busy)};
      check("indicators", {3'h0, ind}, xp);
    end
    for (int t = 0; t < 5; t++) begin
      @(negedge clk);
      ck_en = ck_tab[t][5];
      ck_set = ck_tab[t][4:0];
      per = 2 << ck_set[2:0];
      hi = (ck_set[4:3] == 2'h1) ? per / 4 :
           (ck_set[4:3] == 2'h2) ? 3 * per / 4 : per / 2;
      repeat (20) @(negedge clk);
      cnt = 8'h00;
      repeat (64) begin
        @(negedge clk);
        cnt = cnt + {7'h00, ck_pin === 1'b1};
      end
      xp = ck_en ? 8'(64 * hi / per) : 8'h00;
      check("clock highs", cnt, xp);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
